// file: bench/async_timer_sva.sv
// Purpose: port-level checks of the asynchronous timer register interface
// Assumes: read data one cycle after the read strobe, sync window of 3 cycles
// Notes:   bound to every async_timer instance
`timescale 1ns/100ps

module async_timer_sva #(
  parameter int          NUM_MATCH  = 2,
  parameter int          NUM_TICK   = 2,
  parameter logic [31:0] BUILD_WORD = 32'h0000_0000,
  parameter logic [31:0] REV_WORD   = 32'h0000_0000
) (
  input wire logic        i_clk,
  input wire logic        i_srst,
  input wire logic        i_src_clk,
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic [31:0] o_irq,
  input wire logic [31:0] o_event,
  input wire logic        o_wake,
  input wire logic        o_src_en,
  input wire logic [1:0]  o_src_sel
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  // request drops may lag the clearing write by one cycle
  logic clr;
  logic clr_q;
  assign clr = i_wr && (i_addr == 8'h0C || i_addr == 8'h14);
  always_ff @(posedge i_clk) begin
    clr_q <= clr;
  end

  sequence ctrl_wr_s;
    i_wr && i_addr == 8'h00;
  endsequence
  sequence src_wr_s;
    i_wr && i_addr == 8'h40;
  endsequence
  sequence rd_at(logic [7:0] a);
    i_rd && i_addr == a;
  endsequence

  rdata_idle_a: assert property (!i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data outside its slot");
  prescaler_reset_strobe_reads_zero_a: assert property (rd_at(8'h00) |=> !o_rdata[1])
    else $error("prescaler clear bit read back as one");
  ctrl_busy_zero_a: assert property (ctrl_wr_s ##1 rd_at(8'h00) |=> o_rdata == 32'h0000_0000)
    else $error("control read during sync window not zero");
  status_busy_a: assert property (ctrl_wr_s ##1 rd_at(8'h08) |=> o_rdata[24])
    else $error("sync busy flag not seen after control write");
  src_pending_a: assert property (src_wr_s ##1 rd_at(8'h08) |=> o_rdata[28])
    else $error("source busy flag not seen after source write");
  mask_bits_a: assert property (rd_at(8'h18) |=> (o_rdata & ~async_timer_pkg::FLAG_BITS) == 32'h0000_0000)
    else $error("mask holds a bit with no flag");
  build_word_a: assert property (rd_at(8'hF0) |=> o_rdata == BUILD_WORD)
    else $error("build parameter word wrong");
  rev_word_a: assert property (rd_at(8'hFC) |=> o_rdata == REV_WORD)
    else $error("revision word wrong");
  mask_off_a: assert property (i_wr && i_addr == 8'h14 && i_wdata == 32'hFFFF_FFFF |-> ##[1:2] o_irq == 0)
    else $error("request stayed after full mask clear");
  irq_hold_a: assert property (o_irq[0] && !clr && !clr_q |=> o_irq[0])
    else $error("wrap request dropped without a clear");
endmodule : async_timer_sva

bind async_timer async_timer_sva #(
  .NUM_MATCH(NUM_MATCH), .NUM_TICK(NUM_TICK), .BUILD_WORD(BUILD_WORD), .REV_WORD(REV_WORD)
) u_sva (
  .i_clk(i_clk), .i_srst(i_srst), .i_src_clk(i_src_clk), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_event(o_event), .o_wake(o_wake),
  .o_src_en(o_src_en), .o_src_sel(o_src_sel)
);

// file: bench/testbench.sv
// Purpose: self-checking bench for the asynchronous timer registers
// Assumes: read data valid one cycle after the read strobe
// Notes:   source clock pulses are slow levels made by the bench
`timescale 1ns/100ps

`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); end end

module testbench;
  logic        i_clk;
  logic        i_srst;
  logic        i_src_clk;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [31:0] o_rdata;
  logic [31:0] o_irq;
  logic [31:0] o_event;
  logic        o_wake;
  logic        o_src_en;
  logic [1:0]  o_src_sel;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          n_event = 0;

  async_timer #(.NUM_MATCH(2), .NUM_TICK(2), .BUILD_WORD(32'h0000_0202), .REV_WORD(32'h0000_0100)) dut (
    .i_clk(i_clk), .i_srst(i_srst), .i_src_clk(i_src_clk), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_event(o_event), .o_wake(o_wake),
    .o_src_en(o_src_en), .o_src_sel(o_src_sel)
  );

  task automatic wrap_up;
    if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  // write, then let the sync window close
  task automatic wrs(input logic [7:0] a, input logic [31:0] d);
    wr(a, d);
    repeat (6) @(posedge i_clk);
  endtask : wrs

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask : rd

  // read strobe right behind a write, no gap
  task automatic wr_rd(input logic [7:0] wa, input logic [31:0] wd, input logic [7:0] ra, output logic [31:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= wa;
    i_wdata <= wd;
    @(posedge i_clk);
    i_wr   <= 1'b0;
    i_rd   <= 1'b1;
    i_addr <= ra;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask : wr_rd

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    `CHK(d, exp)
  endtask : chk_rd

  task automatic src_edges(input int n);
    repeat (n) begin
      repeat (4) @(posedge i_clk);
      i_src_clk <= 1'b1;
      repeat (4) @(posedge i_clk);
      i_src_clk <= 1'b0;
    end
    repeat (8) @(posedge i_clk);
  endtask : src_edges

  task automatic test_reset;
    logic [7:0] ofs [14] = '{8'h00, 8'h04, 8'h08, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h30, 8'h34, 8'h40, 8'h44,
                             8'h50, 8'h54, 8'h28};
    foreach (ofs[k]) chk_rd(ofs[k], 32'h0000_0000);
    chk_rd(8'hF0, 32'h0000_0202);
    chk_rd(8'hFC, 32'h0000_0100);
    `CHK(o_irq, 32'h0000_0000)
  endtask : test_reset

  task automatic test_busy;
    logic [31:0] d;
    wr_rd(8'h00, 32'h0000_0103, 8'h08, d);
    `CHK(d[24], 1'b1)
    repeat (6) @(posedge i_clk);
    wr_rd(8'h00, 32'h0000_0103, 8'h00, d);
    `CHK(d, 32'h0000_0000)
    repeat (6) @(posedge i_clk);
    wr(8'h00, 32'h0000_0103);
    wr(8'h04, 32'h0000_0005);
    repeat (6) @(posedge i_clk);
    chk_rd(8'h04, 32'h0000_0000);
    chk_rd(8'h00, 32'h0000_0101);
    chk_rd(8'h08, 32'h0200_0000);
  endtask : test_busy

  task automatic test_source;
    logic [31:0] d;
    wr_rd(8'h40, 32'h0000_0101, 8'h08, d);
    `CHK(d[28], 1'b1)
    repeat (6) @(posedge i_clk);
    chk_rd(8'h08, 32'h2200_0000);
    `CHK(o_src_en, 1'b1)
    `CHK(o_src_sel, 2'h1)
  endtask : test_source

  task automatic test_mask;
    wrs(8'h10, 32'hFFFF_FFFF);
    chk_rd(8'h18, async_timer_pkg::FLAG_BITS);
    `CHK(o_irq, 32'h2200_0000)
    wrs(8'h10, 32'h0000_0000);
    chk_rd(8'h18, async_timer_pkg::FLAG_BITS);
    wrs(8'h14, 32'h0003_0301);
    chk_rd(8'h18, 32'h2200_0000);
    wrs(8'h14, 32'hFFFF_FFFF);
    chk_rd(8'h18, 32'h0000_0000);
    `CHK(o_irq, 32'h0000_0000)
  endtask : test_mask

  task automatic test_count;
    wrs(8'h24, 32'hFFFF_FFF0);
    wrs(8'h20, 32'h0000_0003);
    wrs(8'h34, 32'h0000_0002);
    wrs(8'h30, 32'h0000_0000);
    wrs(8'h00, 32'h0000_0101);
    // prescaler 0 to 6: counter ticks at 1, 3, 5 and clears on match 3
    src_edges(6);
    chk_rd(8'h04, 32'h0000_0000);
    chk_rd(8'h08, 32'h2203_0101);
    wrs(8'h10, 32'h0000_0001);
    wrs(8'h0C, 32'h0003_0301);
    chk_rd(8'h08, 32'h2200_0000);
    `CHK(o_irq, 32'h0000_0000)
    wrs(8'h04, 32'hFFFF_FFFE);
    chk_rd(8'h04, 32'hFFFF_FFFE);
    src_edges(4);
    chk_rd(8'h04, 32'h0000_0000);
    chk_rd(8'h08, 32'h2201_0001);
    `CHK(o_irq, 32'h0000_0001)
    wrs(8'h0C, 32'h0000_0001);
    `CHK(o_irq, 32'h0000_0000)
  endtask : test_count

  // calendar mode wraps silently; event pulses and wake follow their masks
  task automatic test_events;
    wrs(8'h48, 32'h0001_0000);
    wrs(8'h1C, 32'h0000_0001);
    wrs(8'h00, 32'h0000_0005);
    wrs(8'h04, 32'hFFFF_FFFF);
    // prescaler 10 to 11: counter wraps, periodic 0 fires
    src_edges(1);
    chk_rd(8'h04, 32'h0000_0000);
    chk_rd(8'h08, 32'h2201_0000);
    `CHK(o_wake, 1'b0)
    `CHK(n_event, 1)
    wrs(8'h00, 32'h0000_0001);
    wrs(8'h04, 32'hFFFF_FFFF);
    // prescaler 11 to 13: periodic 1 at 12, wrap at 13
    src_edges(2);
    chk_rd(8'h08, 32'h2203_0001);
    `CHK(o_wake, 1'b1)
    `CHK(n_event, 2)
  endtask : test_events

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // one count per cycle of a periodic 0 event pulse
  always @(posedge i_clk) begin
    if (o_event[16] === 1'b1) begin
      n_event++;
    end
  end

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  initial begin
    i_srst    = 1'b1;
    i_src_clk = 1'b0;
    i_addr    = 8'h00;
    i_wdata   = 32'h0000_0000;
    i_wr      = 1'b0;
    i_rd      = 1'b0;
    repeat (16) @(posedge i_clk);
    i_srst <= 1'b0;
    test_reset();
    test_busy();
    test_source();
    test_mask();
    test_count();
    test_events();
    wrap_up();
  end
endmodule : testbench

// file: design/async_timer.sv
// Purpose: register interface and counting core of an asynchronous 32-bit timer
// Assumes: source clock arrives as a slow pin level, sampled on i_clk
// Notes:   prescaler advances on each sampled rising edge of the source clock
//
// Behaviour
// RQ1: counter steps on rising edge of the prescaler bit chosen by the tap field.
// RQ2: clear-on-match bits 8 and 9 make a match clear the counter.
// RQ3: control bit 2 picks plain counter mode or calendar mode.
// RQ4: writing one to control bit 1 clears prescaler; bit reads zero.
// RQ5: control bit 0 enables the timer.
// RQ6: while sync busy, synced writes are dropped and those registers read zero; date/time value at 0x54 still reads the counter.
// RQ7: counter value register at 0x04 reads the counter; writes load it.
// RQ8: status bit 28 is high after source clock control write until ready.
// RQ9: status bit 29 sets when source busy falls.
// RQ10: status bit 25 sets when sync busy falls.
// RQ11: periodic flags 16 and 17 set on rise of their selected prescaler bit.
// RQ12: match flags 8 and 9 set when the counter reaches the match value.
// RQ13: status bit 0 sets on counter overflow.
// RQ14: writing one to status clear at 0x0C clears flag and its request.
// RQ15: writing one to irq enable set at 0x10 sets mask bit.
// RQ16: parameter and revision registers reset to configured, nonzero values.
// RQ17: number of match and tick interval registers is an instance parameter.
// RQ18: request is raised only while masked in, held until flag is cleared.
// RQ19: writing one to irq enable clear at 0x14 clears mask bit.
// RQ20: clear-on-match also sets the overflow flag.
// RQ21: in counter mode overflow means wrap from all ones to zero.
`timescale 1ns/100ps

module async_timer #(
  parameter int          NUM_MATCH  = 2,
  parameter int          NUM_TICK   = 2,
  parameter logic [31:0] BUILD_WORD = 32'h0000_0202,  // arbitrary value
  parameter logic [31:0] REV_WORD   = 32'h0000_0100   // arbitrary value
) (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_src_clk,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  output logic      [31:0] o_irq,
  output logic      [31:0] o_event,
  output logic             o_wake,
  output logic             o_src_en,
  output logic      [1:0]  o_src_sel
);

  async_timer_pkg::state_t q;
  async_timer_pkg::state_t d;

  logic        src_edge;
  logic        busy;
  logic        src_busy;
  logic        wr_ok;
  logic        count_tick;
  logic [31:0] presc_n;
  logic [31:0] cnt_n;
  logic [31:0] set_flags;
  logic [31:0] clr_flags;
  logic [31:0] status_rd;
  logic [31:0] rd_word;
  logic        hit_clear;

  always_comb begin
    d          = q;
    set_flags  = '0;
    clr_flags  = '0;
    hit_clear  = 1'b0;
    rd_word    = '0;

    // two-stage sampling of the source clock pin
    d.src_meta = i_src_clk;
    d.src_sync = q.src_meta;
    d.src_prev = q.src_sync;
    src_edge   = q.src_sync & ~q.src_prev;

    busy     = (q.busy_cnt != 2'h0);
    src_busy = (q.src_busy_cnt != 2'h0);
    wr_ok    = i_wr & ~busy;  // RQ6

    // prescaler runs only while enabled and sourced
    presc_n = q.presc;
    if (q.en && q.src_en && src_edge) begin  // RQ5
      presc_n = q.presc + 32'h0000_0001;
    end
    if (wr_ok && i_addr == async_timer_pkg::TIMER_CONTROL_OFS
        && i_wdata[async_timer_pkg::PRESC_CLEAR_BIT]) begin
      presc_n = '0;  // RQ4
    end

    // counter clocked from the selected prescaler tap
    count_tick = ~q.presc[q.count_tap] & presc_n[q.count_tap];  // RQ1
    cnt_n      = q.cnt;
    if (count_tick) begin
      cnt_n = q.cnt + 32'h0000_0001;
      if (!q.cal && q.cnt == 32'hFFFF_FFFF) begin  // RQ3
        set_flags[async_timer_pkg::WRAP_BIT] = 1'b1;  // RQ13 RQ21
      end
      for (int i = 0; i < async_timer_pkg::MAX_MATCH; i++) begin
        if (i < NUM_MATCH && cnt_n == q.match[i]) begin  // RQ17
          set_flags[async_timer_pkg::MATCH_LSB + i] = 1'b1;  // RQ12
          if (q.clr_on_match[i]) begin
            hit_clear = 1'b1;  // RQ2
          end
        end
      end
      if (hit_clear) begin
        cnt_n = '0;  // RQ2
        set_flags[async_timer_pkg::WRAP_BIT] = 1'b1;  // RQ20
      end
    end

    // periodic taps
    for (int j = 0; j < async_timer_pkg::MAX_TICK; j++) begin
      if (j < NUM_TICK && ~q.presc[q.tick_tap[j]] && presc_n[q.tick_tap[j]]) begin
        set_flags[async_timer_pkg::PERIODIC_LSB + j] = 1'b1;  // RQ11
      end
    end

    // synchroniser busy windows
    if (busy) begin
      d.busy_cnt = q.busy_cnt - 2'h1;
      if (q.busy_cnt == 2'h1) begin
        set_flags[async_timer_pkg::SYNC_DONE_BIT] = 1'b1;  // RQ10
      end
    end
    if (src_busy) begin
      d.src_busy_cnt = q.src_busy_cnt - 2'h1;
      if (q.src_busy_cnt == 2'h1) begin
        set_flags[async_timer_pkg::SRC_READY_BIT] = 1'b1;  // RQ9
      end
    end

    // register writes
    if (i_wr) begin
      case (i_addr)
        async_timer_pkg::TIMER_CONTROL_OFS: begin
          if (wr_ok) begin
            d.en           = i_wdata[async_timer_pkg::ENABLE_BIT];  // RQ5
            d.cal          = i_wdata[async_timer_pkg::CALENDAR_BIT];  // RQ3
            d.clr_on_match = i_wdata[async_timer_pkg::CLR_ON_MATCH_LSB +: async_timer_pkg::MAX_MATCH];  // RQ2
            d.count_tap    = i_wdata[async_timer_pkg::TICK_TAP_LSB +: async_timer_pkg::TAP_W];  // RQ1
          end
        end
        async_timer_pkg::COUNTER_VALUE_OFS,
        async_timer_pkg::DATE_TIME_VALUE_OFS: begin
          if (wr_ok) begin
            cnt_n = i_wdata;  // RQ7
          end
        end
        async_timer_pkg::STATUS_CLEAR_OFS: begin
          if (wr_ok) begin
            clr_flags = i_wdata & async_timer_pkg::FLAG_BITS;  // RQ14
          end
        end
        async_timer_pkg::IRQ_ENABLE_SET_OFS: begin
          d.irq_mask = q.irq_mask | (i_wdata & async_timer_pkg::FLAG_BITS);  // RQ15
        end
        async_timer_pkg::IRQ_ENABLE_CLEAR_OFS: begin
          d.irq_mask = q.irq_mask & ~i_wdata;  // RQ19
        end
        async_timer_pkg::WAKEUP_ENABLE_OFS: begin
          if (wr_ok) begin
            d.wake_en = i_wdata & async_timer_pkg::EVENT_BITS;
          end
        end
        async_timer_pkg::MATCH_VALUE_0_OFS: begin
          if (wr_ok && NUM_MATCH > 0) begin
            d.match[0] = i_wdata;
          end
        end
        async_timer_pkg::MATCH_VALUE_1_OFS: begin
          if (wr_ok && NUM_MATCH > 1) begin
            d.match[1] = i_wdata;
          end
        end
        async_timer_pkg::TICK_INTERVAL_0_OFS: begin
          if (wr_ok && NUM_TICK > 0) begin
            d.tick_tap[0] = i_wdata[async_timer_pkg::TAP_W-1:0];
          end
        end
        async_timer_pkg::TICK_INTERVAL_1_OFS: begin
          if (wr_ok && NUM_TICK > 1) begin
            d.tick_tap[1] = i_wdata[async_timer_pkg::TAP_W-1:0];
          end
        end
        async_timer_pkg::SOURCE_CLOCK_CONTROL_OFS: begin
          d.src_en       = i_wdata[async_timer_pkg::SRC_ENABLE_BIT];
          d.src_sel      = i_wdata[async_timer_pkg::SRC_SEL_LSB +: async_timer_pkg::SRC_SEL_W];
          d.src_busy_cnt = async_timer_pkg::SRC_SYNC_CYCLES;  // RQ8
        end
        async_timer_pkg::RATE_TRIM_OFS: begin
          if (wr_ok) begin
            d.trim = i_wdata;
          end
        end
        async_timer_pkg::TRIGGER_ENABLE_SET_OFS: begin
          if (wr_ok) begin
            d.trig_mask = q.trig_mask | (i_wdata & async_timer_pkg::EVENT_BITS);
          end
        end
        async_timer_pkg::TRIGGER_ENABLE_CLEAR_OFS: begin
          if (wr_ok) begin
            d.trig_mask = q.trig_mask & ~i_wdata;
          end
        end
        default: begin
        end
      endcase
    end

    // writes to synchronised registers open a busy window
    if (wr_ok) begin
      case (i_addr)
        async_timer_pkg::TIMER_CONTROL_OFS,
        async_timer_pkg::COUNTER_VALUE_OFS,
        async_timer_pkg::DATE_TIME_VALUE_OFS,
        async_timer_pkg::STATUS_CLEAR_OFS,
        async_timer_pkg::WAKEUP_ENABLE_OFS,
        async_timer_pkg::MATCH_VALUE_0_OFS,
        async_timer_pkg::MATCH_VALUE_1_OFS,
        async_timer_pkg::TICK_INTERVAL_0_OFS,
        async_timer_pkg::TICK_INTERVAL_1_OFS,
        async_timer_pkg::RATE_TRIM_OFS,
        async_timer_pkg::TRIGGER_ENABLE_SET_OFS,
        async_timer_pkg::TRIGGER_ENABLE_CLEAR_OFS: begin
          d.busy_cnt = async_timer_pkg::SYNC_CYCLES;  // RQ6
        end
        default: begin
        end
      endcase
    end

    d.presc = presc_n;
    d.cnt   = cnt_n;

    // sticky flags: a set in the clearing cycle wins
    d.status = ((q.status & ~clr_flags) | set_flags) & async_timer_pkg::FLAG_BITS;  // RQ14

    // request held while flagged and masked in
    d.irq  = d.status & d.irq_mask;  // RQ18
    d.trig = set_flags & q.trig_mask & async_timer_pkg::EVENT_BITS;
    d.wake = |(d.status & q.wake_en);

    // read path, answer in the following cycle only
    status_rd = q.status;
    status_rd[async_timer_pkg::SYNC_BUSY_BIT]   = busy;
    status_rd[async_timer_pkg::SRC_PENDING_BIT] = src_busy;  // RQ8
    if (i_rd) begin
      case (i_addr)
        async_timer_pkg::TIMER_CONTROL_OFS: begin
          rd_word[async_timer_pkg::ENABLE_BIT]   = q.en;
          rd_word[async_timer_pkg::CALENDAR_BIT] = q.cal;
          rd_word[async_timer_pkg::CLR_ON_MATCH_LSB +: async_timer_pkg::MAX_MATCH] = q.clr_on_match;
          rd_word[async_timer_pkg::TICK_TAP_LSB +: async_timer_pkg::TAP_W]         = q.count_tap;
          if (busy) begin
            rd_word = '0;  // RQ6
          end
        end
        async_timer_pkg::COUNTER_VALUE_OFS: begin
          rd_word = busy ? '0 : q.cnt;  // RQ7
        end
        async_timer_pkg::DATE_TIME_VALUE_OFS: begin
          rd_word = q.cnt;
        end
        async_timer_pkg::TIMER_STATUS_OFS: begin
          rd_word = status_rd;
        end
        async_timer_pkg::IRQ_MASK_STATE_OFS: begin
          rd_word = q.irq_mask;
        end
        async_timer_pkg::WAKEUP_ENABLE_OFS: begin
          rd_word = busy ? '0 : q.wake_en;
        end
        async_timer_pkg::MATCH_VALUE_0_OFS: begin
          rd_word = (busy || NUM_MATCH < 1) ? '0 : q.match[0];
        end
        async_timer_pkg::MATCH_VALUE_1_OFS: begin
          rd_word = (busy || NUM_MATCH < 2) ? '0 : q.match[1];
        end
        async_timer_pkg::TICK_INTERVAL_0_OFS: begin
          if (!busy && NUM_TICK > 0) begin
            rd_word[async_timer_pkg::TAP_W-1:0] = q.tick_tap[0];
          end
        end
        async_timer_pkg::TICK_INTERVAL_1_OFS: begin
          if (!busy && NUM_TICK > 1) begin
            rd_word[async_timer_pkg::TAP_W-1:0] = q.tick_tap[1];
          end
        end
        async_timer_pkg::SOURCE_CLOCK_CONTROL_OFS: begin
          rd_word[async_timer_pkg::SRC_ENABLE_BIT] = q.src_en;
          rd_word[async_timer_pkg::SRC_SEL_LSB +: async_timer_pkg::SRC_SEL_W] = q.src_sel;
        end
        async_timer_pkg::RATE_TRIM_OFS: begin
          rd_word = busy ? '0 : q.trim;
        end
        async_timer_pkg::TRIGGER_MASK_STATE_OFS: begin
          rd_word = q.trig_mask;
        end
        async_timer_pkg::BUILD_PARAMETERS_OFS: begin
          rd_word = BUILD_WORD;  // RQ16
        end
        async_timer_pkg::MODULE_REVISION_OFS: begin
          rd_word = REV_WORD;  // RQ16
        end
        default: begin
          rd_word = '0;
        end
      endcase
    end
    d.rdata = rd_word;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_rdata   = q.rdata;
  assign o_irq     = q.irq;
  assign o_event   = q.trig;
  assign o_wake    = q.wake;
  assign o_src_en  = q.src_en;
  assign o_src_sel = q.src_sel;

endmodule : async_timer

// file: design/async_timer_pkg.sv
// Purpose: constants, register map and state layout of the asynchronous timer
// Assumes: one 32-bit register per aligned word, byte addresses as offsets
// Notes:   shared by the design and the bench
package async_timer_pkg;

  // register offsets
  localparam logic [7:0] TIMER_CONTROL_OFS        = 8'h00;
  localparam logic [7:0] COUNTER_VALUE_OFS        = 8'h04;
  localparam logic [7:0] TIMER_STATUS_OFS         = 8'h08;
  localparam logic [7:0] STATUS_CLEAR_OFS         = 8'h0C;
  localparam logic [7:0] IRQ_ENABLE_SET_OFS       = 8'h10;
  localparam logic [7:0] IRQ_ENABLE_CLEAR_OFS     = 8'h14;
  localparam logic [7:0] IRQ_MASK_STATE_OFS       = 8'h18;
  localparam logic [7:0] WAKEUP_ENABLE_OFS        = 8'h1C;
  localparam logic [7:0] MATCH_VALUE_0_OFS        = 8'h20;
  localparam logic [7:0] MATCH_VALUE_1_OFS        = 8'h24;
  localparam logic [7:0] TICK_INTERVAL_0_OFS      = 8'h30;
  localparam logic [7:0] TICK_INTERVAL_1_OFS      = 8'h34;
  localparam logic [7:0] SOURCE_CLOCK_CONTROL_OFS = 8'h40;
  localparam logic [7:0] RATE_TRIM_OFS            = 8'h44;
  localparam logic [7:0] TRIGGER_ENABLE_SET_OFS   = 8'h48;
  localparam logic [7:0] TRIGGER_ENABLE_CLEAR_OFS = 8'h4C;
  localparam logic [7:0] TRIGGER_MASK_STATE_OFS   = 8'h50;
  localparam logic [7:0] DATE_TIME_VALUE_OFS      = 8'h54;
  localparam logic [7:0] BUILD_PARAMETERS_OFS     = 8'hF0;
  localparam logic [7:0] MODULE_REVISION_OFS      = 8'hFC;

  // timer_control fields
  localparam int ENABLE_BIT       = 0;
  localparam int PRESC_CLEAR_BIT  = 1;
  localparam int CALENDAR_BIT     = 2;
  localparam int CLR_ON_MATCH_LSB = 8;
  localparam int TICK_TAP_LSB     = 16;
  localparam int TAP_W            = 5;

  // timer_status fields
  localparam int WRAP_BIT         = 0;
  localparam int MATCH_LSB        = 8;
  localparam int PERIODIC_LSB     = 16;
  localparam int SYNC_BUSY_BIT    = 24;
  localparam int SYNC_DONE_BIT    = 25;
  localparam int SRC_PENDING_BIT  = 28;
  localparam int SRC_READY_BIT    = 29;
  localparam logic [31:0] FLAG_BITS  = 32'h2203_0301;
  localparam logic [31:0] EVENT_BITS = 32'h0003_0301;

  // source_clock_control fields
  localparam int SRC_ENABLE_BIT   = 0;
  localparam int SRC_SEL_LSB      = 8;
  localparam int SRC_SEL_W        = 2;

  // channel counts and reset values
  localparam int MAX_MATCH = 2;
  localparam int MAX_TICK  = 2;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // synchroniser delays in i_clk cycles
  localparam logic [1:0] SYNC_CYCLES     = 2'h3;
  localparam logic [1:0] SRC_SYNC_CYCLES = 2'h3;

  typedef struct packed {
    logic                           src_meta;
    logic                           src_sync;
    logic                           src_prev;
    logic [31:0]                    presc;
    logic [31:0]                    cnt;
    logic                           en;
    logic                           cal;
    logic [MAX_MATCH-1:0]           clr_on_match;
    logic [TAP_W-1:0]               count_tap;
    logic [MAX_MATCH-1:0][31:0]     match;
    logic [MAX_TICK-1:0][TAP_W-1:0] tick_tap;
    logic [31:0]                    status;
    logic [1:0]                     busy_cnt;
    logic [1:0]                     src_busy_cnt;
    logic [31:0]                    irq_mask;
    logic [31:0]                    wake_en;
    logic [31:0]                    trig_mask;
    logic                           src_en;
    logic [SRC_SEL_W-1:0]           src_sel;
    logic [31:0]                    trim;
    logic [31:0]                    rdata;
    logic [31:0]                    irq;
    logic [31:0]                    trig;
    logic                           wake;
  } state_t;

endpackage : async_timer_pkg
